// file: src/host_port_pkg.sv
/*
 Constants for the eight-channel serial device host bus port: address field
 layout, bus-style strap encoding and read/write direction codes.
 Assumes nothing of its surroundings; imported whole by host_bus_port and the verification modules.
*/
package host_port_pkg;

   // ==========================================================
   // Address and data layout
   // ==========================================================
   localparam int ADDR_W        = 8;   // Host address width
   localparam int DATA_W        = 8;   // Host data width
   localparam int REG_SEL_LSB   = 0;   // Register select field low bit
   localparam int REG_SEL_W     = 4;   // Sixteen registers per channel
   localparam int CHAN_SEL_LSB  = 4;   // Channel select field low bit
   localparam int CHAN_SEL_W    = 3;   // Eight channels
   localparam int GLOBAL_BIT    = 7;   // Global register space select
   localparam int NUM_CHAN      = 8;   // Channel count

   // ==========================================================
   // Strap and direction encodings
   // ==========================================================
   localparam logic STYLE_SPLIT  = 1'b1; // Separate read and write strobes
   localparam logic STYLE_SINGLE = 1'b0; // One strobe plus direction line
   localparam logic DIR_READ     = 1'b1; // Direction line high means read
   localparam logic DIR_WRITE    = 1'b0; // Direction line low means write

   // Access phase of the port
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_READ  = 2'b01,
      ST_WRITE = 2'b10
   } access_state_e;

endpackage : host_port_pkg

// file: src/strobe_edge.sv
/*
 Edge detector for one active-low host strobe after conditioning.
 Assumes the strobe level is already synchronous to ref_clk.
*/
`timescale 1ns/1ps
module strobe_edge (
   input  wire logic ref_clk,    // Device clock
   input  wire logic rst_sync_n, // Synchronised reset
   input  wire logic level_n,    // Active-low strobe level
   output logic      fall,       // One-cycle pulse on assertion
   output logic      rise        // One-cycle pulse on release
);
   logic prev_reg; // Level seen last cycle

   // ==========================================================
   // History register
   // ==========================================================
   // Idles high so no spurious edge leaves reset
   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         prev_reg <= 1'b1;
      end else begin
         prev_reg <= level_n;
      end
   end

   assign fall = prev_reg & ~level_n; // High to low
   assign rise = ~prev_reg & level_n; // Low to high
endmodule : strobe_edge

// file: src/host_bus_port.sv
/*
 Host parallel bus port of an eight-channel serial device: decodes the host
 address into channel, register and global space, runs read and write cycles
 in either host bus style, drives the shared data bus and the open-drain
 interrupt line.
 Assumes host pins are synchronous to ref_clk and that the register file
 behind the port answers rd_data combinationally from the decoded address.
*/
`timescale 1ns/1ps
module host_bus_port
   import host_port_pkg::*;
#(
   parameter int NCHAN = NUM_CHAN // Channels feeding the interrupt line
) (
   input  wire logic                  ref_clk,         // 250 MHz device clock
   input  wire logic                  rst_n,           // Asynchronous reset
   input  wire logic                  bus_style,       // Strap: 1 split, 0 single
   input  wire logic [ADDR_W-1:0]     host_addr,       // Host address
   input  wire logic                  chip_select_n,   // Chip select or strobe
   input  wire logic                  read_strobe_n,   // Read strobe
   input  wire logic                  write_strobe_n,  // Write strobe or direction
   input  wire logic [DATA_W-1:0]     host_data_in,    // Data bus level
   output logic      [DATA_W-1:0]     host_data_out,   // Data bus drive value
   output logic                       host_data_oe,    // Data bus drive enable
   input  wire logic [NCHAN-1:0]      chan_irq,        // Per-channel interrupt
   output logic                       irq_n_out,       // Interrupt pin value
   output logic                       irq_n_oe,        // Interrupt pin pull enable
   output logic      [CHAN_SEL_W-1:0] chan_sel,        // Decoded channel
   output logic      [REG_SEL_W-1:0]  reg_sel,         // Decoded register
   output logic                       global_sel,      // Global space selected
   output logic                       rd_start,        // Read begins
   input  wire logic [DATA_W-1:0]     rd_data,         // Byte from register file
   output logic                       wr_start,        // Write cycle begins
   output logic                       wr_commit,       // Write byte valid
   output logic      [DATA_W-1:0]     wr_data          // Latched write byte
);

   // ==========================================================
   // Reset release
   // ==========================================================
   logic rst_meta_reg; // First reset stage
   logic rst_sync_n;   // Released reset used everywhere

   // Asserts at once, releases after two edges
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_reg <= 1'b0;
         rst_sync_n   <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_n   <= rst_meta_reg;
      end
   end

   // ==========================================================
   // Strobe conditioning per bus style
   // ==========================================================
   wire split_style = (bus_style == STYLE_SPLIT);
   // Split style gates each strobe with chip select
   wire rd_lvl_split_n = read_strobe_n | chip_select_n;
   wire wr_lvl_split_n = write_strobe_n | chip_select_n;
   // Single style: chip select strobes, write pin gives direction
   wire dir_is_read    = (write_strobe_n == DIR_READ);
   wire rd_lvl_one_n   = chip_select_n | ~dir_is_read;
   wire wr_lvl_one_n   = chip_select_n | dir_is_read;
   // Read strobe pin is ignored in single style; host ties it high
   wire rd_lvl_n = split_style ? rd_lvl_split_n : rd_lvl_one_n;
   wire wr_lvl_n = split_style ? wr_lvl_split_n : wr_lvl_one_n;

   logic rd_fall; // Read access begins
   logic rd_rise; // Read access ends
   logic wr_fall; // Write access begins
   logic wr_rise; // Write access ends

   // Edge detection for read access
   strobe_edge u_rd_edge (
      .ref_clk    (ref_clk),
      .rst_sync_n (rst_sync_n),
      .level_n    (rd_lvl_n),
      .fall       (rd_fall),
      .rise       (rd_rise)
   );

   // Edge detection for write access
   strobe_edge u_wr_edge (
      .ref_clk    (ref_clk),
      .rst_sync_n (rst_sync_n),
      .level_n    (wr_lvl_n),
      .fall       (wr_fall),
      .rise       (wr_rise)
   );

   // ==========================================================
   // Address decode
   // ==========================================================
   // Field extraction applied to the captured address
   function automatic logic [REG_SEL_W-1:0] reg_field(input logic [ADDR_W-1:0] a);
      reg_field = a[REG_SEL_LSB +: REG_SEL_W];
   endfunction : reg_field

   function automatic logic [CHAN_SEL_W-1:0] chan_field(input logic [ADDR_W-1:0] a);
      chan_field = a[CHAN_SEL_LSB +: CHAN_SEL_W];
   endfunction : chan_field

   logic [ADDR_W-1:0] addr_reg; // Address held for the access

   // ==========================================================
   // Access state machine
   // ==========================================================
   access_state_e state_reg;  // Current phase
   access_state_e state_next; // Next phase

   // Falling edges open an access, rising edges close it
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (rd_fall) begin
               state_next = ST_READ;
            end else if (wr_fall) begin
               state_next = ST_WRITE;
            end
         end
         ST_READ: begin
            if (rd_rise) begin
               state_next = ST_IDLE;
            end
         end
         ST_WRITE: begin
            if (wr_rise) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   wire open_rd = (state_reg == ST_IDLE) && rd_fall;
   wire open_wr = (state_reg == ST_IDLE) && !rd_fall && wr_fall;
   wire close_wr = (state_reg == ST_WRITE) && wr_rise;

   // State register and address capture at access start
   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         state_reg <= ST_IDLE;
         addr_reg  <= '0;
      end else begin
         state_reg <= state_next;
         if (open_rd || open_wr) begin
            addr_reg <= host_addr;
         end
      end
   end

   // Decoded selects follow the address of the open access
   assign reg_sel    = reg_field(addr_reg);
   assign chan_sel   = chan_field(addr_reg);
   assign global_sel = addr_reg[GLOBAL_BIT];
   assign rd_start   = open_rd;
   assign wr_start   = open_wr;

   // ==========================================================
   // Data path
   // ==========================================================
   logic [DATA_W-1:0] rd_byte_reg;   // Byte driven on reads
   logic              drive_reg;     // Bus drive enable
   logic              wr_commit_reg; // Write commit pulse

   // Read byte loads one cycle after start so rd_data sees the new address;
   // write byte latched from the bus on the closing edge
   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         rd_byte_reg   <= '0;
         drive_reg     <= 1'b0;
         wr_data       <= '0;
         wr_commit_reg <= 1'b0;
      end else begin
         drive_reg     <= (state_next == ST_READ);
         wr_commit_reg <= close_wr;
         if (state_reg == ST_READ) begin
            rd_byte_reg <= rd_data;
         end
         if (close_wr) begin
            wr_data <= host_data_in;
         end
      end
   end

   assign host_data_out = rd_byte_reg;
   assign host_data_oe  = drive_reg;
   assign wr_commit     = wr_commit_reg;

   // ==========================================================
   // Interrupt line
   // ==========================================================
   logic irq_reg; // Any channel requesting

   // Combine all channels; pin only ever pulls low
   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |chan_irq;
      end
   end

   assign irq_n_out = 1'b0;     // Drive value is always low
   assign irq_n_oe  = irq_reg;  // Released otherwise for pull-up

endmodule : host_bus_port

// file: verification/host_bus_port_checker.sv
/* Port checker for the host bus port.
 Assumes it is bound to the top module and sees its ports only. */
`timescale 1ns/1ps
module host_bus_port_checker
   import host_port_pkg::*;
#(
   parameter int NCHAN = NUM_CHAN
) (
   input wire logic                  ref_clk,
   input wire logic                  rst_n,
   input wire logic                  bus_style,
   input wire logic [ADDR_W-1:0]     host_addr,
   input wire logic                  chip_select_n,
   input wire logic                  read_strobe_n,
   input wire logic                  write_strobe_n,
   input wire logic [DATA_W-1:0]     host_data_out,
   input wire logic                  host_data_oe,
   input wire logic [NCHAN-1:0]      chan_irq,
   input wire logic                  irq_n_out,
   input wire logic                  irq_n_oe,
   input wire logic [CHAN_SEL_W-1:0] chan_sel,
   input wire logic [REG_SEL_W-1:0]  reg_sel,
   input wire logic                  global_sel,
   input wire logic                  rd_start,
   input wire logic [DATA_W-1:0]     rd_data,
   input wire logic                  wr_start,
   input wire logic                  wr_commit
);
   // ==========================================================
   // Assertions, all on the device clock
   // ==========================================================
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   a_decode_fields: assert property (rd_start || wr_start |=>
      {global_sel, chan_sel, reg_sel} == $past(host_addr))
      else $error("decoded address differs");
   a_read_drive: assert property (rd_start |=> host_data_oe)
      else $error("read did not drive bus");
   a_read_byte: assert property ($rose(host_data_oe) |=> host_data_out == $past(rd_data))
      else $error("read byte wrong");
   a_write_quiet: assert property (wr_start |-> ##1 !host_data_oe [*2])
      else $error("bus driven in write");
   a_write_done: assert property (wr_start |-> ##[2:64] wr_commit)
      else $error("write never committed");
   a_commit_pulse: assert property (wr_commit |=> !wr_commit)
      else $error("commit longer than one cycle");
   a_split_select: assert property (bus_style && chip_select_n |-> !rd_start && !wr_start)
      else $error("access without chip select");
   a_single_strobe: assert property (!bus_style && chip_select_n |-> !rd_start && !wr_start)
      else $error("access without strobe");
   a_single_dir: assert property (!bus_style && (rd_start || wr_start) |-> rd_start == write_strobe_n)
      else $error("direction decoded wrongly");
   a_split_read: assert property (bus_style && rd_start |-> !read_strobe_n)
      else $error("read without read strobe");
   a_irq_pull: assert property (irq_n_out == 1'b0 && irq_n_oe == $past(|chan_irq))
      else $error("interrupt pull wrong");
   c_read: cover property (rd_start ##1 host_data_oe);
   c_write: cover property (wr_start ##[2:8] wr_commit);
   c_irq: cover property ($rose(irq_n_oe));
endmodule : host_bus_port_checker
bind host_bus_port host_bus_port_checker #(.NCHAN(NCHAN)) u_chk (
   .ref_clk        (ref_clk),
   .rst_n          (rst_n),
   .bus_style      (bus_style),
   .host_addr      (host_addr),
   .chip_select_n  (chip_select_n),
   .read_strobe_n  (read_strobe_n),
   .write_strobe_n (write_strobe_n),
   .host_data_out  (host_data_out),
   .host_data_oe   (host_data_oe),
   .chan_irq       (chan_irq),
   .irq_n_out      (irq_n_out),
   .irq_n_oe       (irq_n_oe),
   .chan_sel       (chan_sel),
   .reg_sel        (reg_sel),
   .global_sel     (global_sel),
   .rd_start       (rd_start),
   .rd_data        (rd_data),
   .wr_start       (wr_start),
   .wr_commit      (wr_commit)
);

// file: verification/host_model.sv
/* Behavioural host processor on the parallel bus.
 Assumes the bench sets the style strap while the bus is idle. */
`timescale 1ns/1ps
module host_model
   import host_port_pkg::*;
(
   input  wire logic              ref_clk,
   input  wire logic              style,
   input  wire logic [DATA_W-1:0] dout,
   input  wire logic              oe,
   output logic                   cs_n,
   output logic                   rd_n,
   output logic                   wr_n,
   output logic      [ADDR_W-1:0] addr,
   output logic      [DATA_W-1:0] bus
);
   logic [DATA_W-1:0] drv  = 8'h00; // Host drive value
   logic              hdrv = 1'b0;  // Host drives the bus
   initial {cs_n, rd_n, wr_n, addr} = {3'b111, 8'h00};
   // Released bus shows the inverse of the last host byte, so a late sample is caught
   assign bus = oe ? dout : (hdrv ? drv : ~drv);
   // One access: strobes held three rising edges, data held past release
   task automatic access(input logic rd, input logic sel, input logic [ADDR_W-1:0] a,
                         input logic [DATA_W-1:0] w, output logic [DATA_W-1:0] r);
      @(negedge ref_clk);
      addr = a;
      hdrv = !rd;
      drv  = w;
      wr_n = rd;              // Split write strobe, or direction high read
      rd_n = !(style && rd);  // Tied high in single style
      cs_n = !sel;
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      r = bus;
      {cs_n, rd_n, wr_n} = 3'b111;
      repeat (2) @(negedge ref_clk);
      hdrv = 1'b0;
   endtask : access
endmodule : host_model

// file: verification/host_bus_port_tb.sv
/* Self-checking bench for the host bus port.
 Assumes the host model owns the bus pins; the bench models the register file. */
`timescale 1ns/1ps
module host_bus_port_tb;
   import host_port_pkg::*;
   logic ref_clk = 1'b0, rst_n = 1'b0, bus_style = 1'b1, live = 1'b0;
   logic [7:0] chan_irq = 8'h00, a, w, r, dout, wr_data, bus, host_addr;
   logic rd, oe, cs_n, rd_n, wr_n, irq_n_out, irq_n_oe, global_sel, rd_start, wr_start, wr_commit;
   logic [2:0] chan_sel;
   logic [3:0] reg_sel;
   logic [7:0] rd_data;
   logic [15:0] exp_q[$];
   logic irq_prev = 1'b0;                      // Interrupt request seen at the last rising edge
   localparam logic [7:0] POLL_ADDR = 8'h80;   // Global space, where the host looks for the source
   int num_errors = 0, n_checks = 0, n_acc = 0, s0;
   // ==========================================================
   // Clock, register file model and instances
   // ==========================================================
   initial forever #2 ref_clk = ~ref_clk;
   assign rd_data = {global_sel, chan_sel, reg_sel} ^ 8'hA5;
   host_model u_host (.ref_clk(ref_clk), .style(bus_style), .dout(dout), .oe(oe), .cs_n(cs_n),
                      .rd_n(rd_n), .wr_n(wr_n), .addr(host_addr), .bus(bus));
   host_bus_port u_host_bus_port (.ref_clk(ref_clk), .rst_n(rst_n), .bus_style(bus_style),
      .host_addr(host_addr), .chip_select_n(cs_n), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
      .host_data_in(bus), .host_data_out(dout), .host_data_oe(oe), .chan_irq(chan_irq),
      .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe), .chan_sel(chan_sel), .reg_sel(reg_sel),
      .global_sel(global_sel), .rd_start(rd_start), .rd_data(rd_data), .wr_start(wr_start),
      .wr_commit(wr_commit), .wr_data(wr_data));
   task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : check
   task automatic report_and_stop;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : report_and_stop
   // Monitor at the rising edge, before the design updates: the start pulses
   // only stand in the half cycle ending at the edge that takes them
   always @(posedge ref_clk) begin
      if (live) begin
         if (rd_start === 1'b1 || wr_start === 1'b1) n_acc++;
         if (wr_commit === 1'b1) begin
            check("write pending", 8'h01, {7'h00, exp_q.size() != 0});
            if (exp_q.size() != 0) begin
               check("write byte", exp_q[0][7:0], wr_data);
               check("write addr", exp_q[0][15:8], {global_sel, chan_sel, reg_sel});
               void'(exp_q.pop_front());
            end
         end
         check("irq pull", {7'h00, irq_prev}, {irq_n_out, 6'h00, irq_n_oe});
      end
      irq_prev <= |chan_irq;
   end
   // Main sequence: random accesses in both styles, some without select
   initial begin
      void'($urandom(32'h8D409754));
      repeat (16) @(negedge ref_clk);
      rst_n = 1'b1;
      repeat (3) @(negedge ref_clk);
      live = 1'b1;
      for (int i = 0; i < 200; i++) begin
         {a, w, rd, bus_style} = {8'($urandom), 8'($urandom), 2'($urandom)};
         chan_irq <= w & {8{rd}};
         s0 = n_acc;
         // Commit is seen before the access returns, so the expectation goes first
         if (!rd && i % 7 != 3) exp_q.push_back({a, w});
         u_host.access(rd, i % 7 != 3, a, w, r);
         if (i % 7 == 3) check("refused", 8'(s0), 8'(n_acc));
         else begin
            check("starts", 8'(s0 + 1), 8'(n_acc));
            if (rd) check("read byte", a ^ 8'hA5, r);
         end
         check("bus drive", 8'h00, {7'h00, oe});
      end
      // Shared line: raise one channel, then poll the global space for the source
      chan_irq <= 8'(1 << ($urandom % NUM_CHAN));
      repeat (2) @(negedge ref_clk);
      check("irq raised", 8'h01, {7'h00, irq_n_oe});
      u_host.access(1'b1, 1'b1, POLL_ADDR, 8'h00, r);
      check("poll read", POLL_ADDR ^ 8'hA5, r);
      check("writes left", 8'h00, 8'(exp_q.size()));
      report_and_stop();
   end
   initial begin
      repeat (100000) @(posedge ref_clk);
      num_errors++;
      report_and_stop();
   end
endmodule : host_bus_port_tb
